// >>> src/btx_pkg.sv
// Shared constants, carriers and states of the burst transmitter packet control.
// Assumes a single 20 MHz clock; all times are converted to cycles here.
package btx_pkg;

  localparam int CLK_HZ        = 20_000_000;
  localparam int CLK_PER_US    = CLK_HZ / 1_000_000;

  // Configuration word layout
  localparam int              CFG_W         = 18;
  localparam logic [17:0]     CFG_RESET     = 18'h1_0f04;
  localparam logic [17:0]     CFG_ALL_ONES  = 18'h3_ffff;
  localparam int              CFG_CRC_L     = 17;
  localparam int              CFG_CRC_EN    = 16;
  localparam int              CFG_COMM_MODE = 14;
  localparam int              CFG_RATE      = 13;

  // Packet layout
  localparam int              PKT_BITS      = 256;
  localparam int              PRE_BITS      = 8;
  localparam logic [7:0]      PRE_ADDR0     = 8'h55;
  localparam logic [7:0]      PRE_ADDR1     = 8'haa;
  localparam int              ADDR_MIN      = 8;
  localparam int              ADDR_MAX      = 40;
  localparam int              CRC_SHORT     = 8;
  localparam int              CRC_LONG      = 16;
  localparam logic [15:0]     CRC16_POLY    = 16'h1021;
  localparam logic [7:0]      CRC8_POLY     = 8'h07;
  localparam logic [15:0]     CRC_INIT      = 16'hffff;

  // Timing
  localparam int T_PD2SBY_US   = 3000;
  localparam int T_SB2TX_US    = 195;
  localparam int RATE_LO_BPS   = 250_000;
  localparam int RATE_HI_BPS   = 1_000_000;
  localparam int PD2SBY_CYC    = T_PD2SBY_US * CLK_PER_US;
  localparam int SB2TX_CYC     = T_SB2TX_US * CLK_PER_US;
  localparam int BIT_CYC_LO    = CLK_HZ / RATE_LO_BPS;
  localparam int BIT_CYC_HI    = CLK_HZ / RATE_HI_BPS;

  // Register port map (word indices)
  localparam logic [2:0] REG_CTRL     = 3'h0;
  localparam logic [2:0] REG_ADDR_LO  = 3'h1;
  localparam logic [2:0] REG_ADDR_HI  = 3'h2;
  localparam logic [2:0] REG_STATUS   = 3'h3;
  localparam logic [2:0] REG_CONFIG   = 3'h4;
  localparam logic [2:0] REG_AIRTIME  = 3'h5;
  localparam int         CTRL_PWR_UP  = 0;
  localparam int         ALEN_LSB     = 8;
  localparam logic [5:0] ALEN_RESET   = 6'h28;

  typedef struct packed {
    logic cfg_select;
    logic tx_activate;
    logic serial_clock;
    logic data;
  } btx_pins_t;

  typedef enum logic [7:0] {
    S_POWER_DOWN_STATE = 8'h01,
    S_SETTLE           = 8'h02,
    S_STANDBY_STATE    = 8'h04,
    S_CONFIG           = 8'h08,
    S_LOAD             = 8'h10,
    S_BURST_WAIT       = 8'h20,
    S_SEND             = 8'h40,
    S_DIRECT           = 8'h80
  } btx_state_t;

endpackage

// >>> src/btx_bit_mem.sv
// Payload bit store for one burst packet.
// Assumes one writer and one reader on the same clock; read data is registered.
`timescale 1ns/1ns
`default_nettype none
module btx_bit_mem #(
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic          wdata,
  input  wire logic [AW-1:0] raddr,
  output var  logic          rdata
);
  logic [DEPTH-1:0] mem;

  // No reset: contents are only read after being written
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // btx_bit_mem
`default_nettype wire

// >>> src/btx_packet_ctrl.sv
// Transmitter packet assembly and mode sequencing behind the radio port.
// Assumes radio port pins are asynchronous; register port is on clk.
`timescale 1ns/1ns
`default_nettype none
module btx_packet_ctrl
  import btx_pkg::*;
#(
  parameter int PD2SBY_CYCLES = PD2SBY_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        cfg_select,
  input  wire logic        tx_activate,
  input  wire logic        radio_serial_clock,
  input  wire logic        radio_data,
  input  wire logic [2:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [31:0] reg_rdata,
  output var  logic        tx_on,
  output var  logic        tx_bit
);
  btx_pins_t  pin_s1_reg, pin_s2_reg, pin_d_reg;
  btx_state_t st_reg, st_next;
  logic [15:0] wait_reg, wait_next;
  logic [6:0]  bitc_reg, bitc_next;
  logic [9:0]  idx_reg, idx_next;
  logic [8:0]  plen_reg, plen_next;
  logic [17:0] cfg_reg, cfg_next, shift_reg, shift_next;
  logic [4:0]  ncfg_reg, ncfg_next;
  logic        valid_reg, valid_next, pwr_reg, pwr_next;
  logic [15:0] crc_reg, crc_next;
  logic        on_reg, on_next, bit_reg, bit_next;
  logic [39:0] addr_reg, addr_next;
  logic [5:0]  alen_reg, alen_next;
  logic [9:0]  last_reg, last_next;
  logic [31:0] rd_reg, rd_next;

  logic        sclk_rise, cs_fall, ce_fall, tick, mem_rd, mem_we, fb, b;
  logic [5:0]  alen;
  logic [4:0]  crc_len;
  logic [8:0]  cap;
  logic [9:0]  a_end, p_end, total;
  logic [6:0]  bit_cyc;
  logic [7:0]  pre, mem_raddr;
  logic [5:0]  ai;
  logic [17:0] mask;

  // Two flops before any pin is looked at
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_reg <= '0;
      pin_s2_reg <= '0;
      pin_d_reg  <= '0;
    end else begin
      pin_s1_reg <= {cfg_select, tx_activate, radio_serial_clock, radio_data};
      pin_s2_reg <= pin_s1_reg;
      pin_d_reg  <= pin_s2_reg;
    end
  end

  assign sclk_rise = pin_s2_reg.serial_clock & ~pin_d_reg.serial_clock;
  assign cs_fall   = ~pin_s2_reg.cfg_select & pin_d_reg.cfg_select;
  assign ce_fall   = ~pin_s2_reg.tx_activate & pin_d_reg.tx_activate;

  assign alen = (alen_reg < 6'(ADDR_MIN)) ? 6'(ADDR_MIN) :
                (alen_reg > 6'(ADDR_MAX)) ? 6'(ADDR_MAX) : alen_reg;
  assign crc_len = !cfg_reg[CFG_CRC_EN] ? 5'd0 :
                   cfg_reg[CFG_CRC_L] ? 5'(CRC_LONG) : 5'(CRC_SHORT);
  assign cap     = 9'(PKT_BITS) - 9'(alen) - 9'(crc_len);
  assign a_end   = 10'(PRE_BITS) + 10'(alen);
  assign p_end   = a_end + 10'(plen_reg);
  assign total   = p_end + 10'(crc_len);
  assign bit_cyc = cfg_reg[CFG_RATE] ? 7'(BIT_CYC_HI) : 7'(BIT_CYC_LO);
  assign tick    = (st_reg == S_SEND) && (bitc_reg == 7'd0);
  // preamble picked by first address bit
  assign pre     = addr_reg[alen - 6'd1] ? PRE_ADDR1 : PRE_ADDR0;
  assign ai      = alen - 6'd1 - 6'(idx_reg - 10'(PRE_BITS));
  assign mem_raddr = 8'(idx_reg - a_end);
  assign mem_we  = (st_reg == S_LOAD) && sclk_rise && (plen_reg < cap);
  // only the bits actually shifted are replaced
  assign mask    = ~(CFG_ALL_ONES << ncfg_reg);

  btx_bit_mem #(
    .DEPTH (PKT_BITS),
    .AW    (8)
  ) u_mem (
    .clk   (clk),
    .we    (mem_we),
    .waddr (plen_reg[7:0]),
    .wdata (pin_s2_reg.data),
    .raddr (mem_raddr),
    .rdata (mem_rd)
  );

  always_comb begin
    st_next = st_reg;    wait_next = wait_reg;  bitc_next = bitc_reg;
    idx_next = idx_reg;  plen_next = plen_reg;  cfg_next = cfg_reg;
    shift_next = shift_reg;  ncfg_next = ncfg_reg;  valid_next = valid_reg;
    pwr_next = pwr_reg;  crc_next = crc_reg;    on_next = on_reg;
    bit_next = bit_reg;  addr_next = addr_reg;  alen_next = alen_reg;
    last_next = last_reg;
    rd_next = 32'h0000_0000;
    b = 1'b0;
    fb = 1'b0;
    case (st_reg)
      S_POWER_DOWN_STATE: begin
        on_next = 1'b0;
        if (pwr_reg) begin
          st_next = S_SETTLE;
          wait_next = 16'(PD2SBY_CYCLES - 1);
        end
      end
      // settle in standby before any mode
      S_SETTLE: begin
        if (wait_reg == 16'd0) begin
          st_next = S_STANDBY_STATE;
        end else begin
          wait_next = wait_reg - 16'd1;
        end
      end
      S_STANDBY_STATE: begin
        on_next = 1'b0;
        if (!pwr_reg) begin
          st_next = S_POWER_DOWN_STATE;
        end else if (pin_s2_reg.cfg_select && !pin_s2_reg.tx_activate) begin
          st_next = S_CONFIG;
          ncfg_next = 5'd0;
        // configured device goes straight to active
        end else if (pin_s2_reg.tx_activate && !pin_s2_reg.cfg_select && valid_reg) begin
          // mode bit picks burst or direct
          if (cfg_reg[CFG_COMM_MODE]) begin
            st_next = S_LOAD;
            plen_next = 9'd0;
          end else begin
            st_next = S_DIRECT;
          end
        end
      end
      S_CONFIG: begin
        // MSB first on serial clock rise
        if (sclk_rise) begin
          shift_next = {shift_reg[16:0], pin_s2_reg.data};
          if (ncfg_reg < 5'(CFG_W)) begin
            ncfg_next = ncfg_reg + 5'd1;
          end
        end
        if (cs_fall) begin
          // a valid word is only held once written
          cfg_next = (cfg_reg & ~mask) | (shift_reg & mask);
          valid_next = 1'b1;
          st_next = S_STANDBY_STATE;
        end
      end
      S_LOAD: begin
        if (mem_we) begin
          plen_next = plen_reg + 9'd1;
        end
        if (ce_fall) begin
          st_next = S_BURST_WAIT;
          wait_next = 16'(SB2TX_CYC - 1);
        end
      end
      S_BURST_WAIT: begin
        crc_next = CRC_INIT;
        idx_next = 10'd0;
        bitc_next = 7'd0;
        if (wait_reg == 16'd0) begin
          st_next = S_SEND;
          on_next = 1'b1;
        end else begin
          wait_next = wait_reg - 16'd1;
        end
      end
      S_SEND: begin
        if (!tick) begin
          bitc_next = bitc_reg - 7'd1;
        end else if (idx_reg == total) begin
          last_next = total;
          on_next = 1'b0;
          st_next = S_STANDBY_STATE;
        end else begin
          // sections follow one another by bit index
          if (idx_reg < 10'(PRE_BITS)) begin
            // preamble made here in burst mode
            b = pre[3'd7 - idx_reg[2:0]];
          end else if (idx_reg < a_end) begin
            b = addr_reg[ai];
          end else if (idx_reg < p_end) begin
            b = mem_rd;
          end else begin
            // CRC sent MSB first when enabled
            b = (crc_len == 5'(CRC_LONG)) ? crc_reg[15] : crc_reg[7];
            crc_next = {crc_reg[14:0], 1'b0};
          end
          if (idx_reg >= 10'(PRE_BITS) && idx_reg < p_end) begin
            if (crc_len == 5'(CRC_LONG)) begin
              fb = b ^ crc_reg[15];
              crc_next = {crc_reg[14:0], 1'b0} ^ (fb ? CRC16_POLY : 16'h0000);
            end else begin
              fb = b ^ crc_reg[7];
              crc_next = {8'h00, {crc_reg[6:0], 1'b0} ^ (fb ? CRC8_POLY : 8'h00)};
            end
          end
          bit_next = b;
          idx_next = idx_reg + 10'd1;
          bitc_next = bit_cyc - 7'd1;
        end
      end
      // direct mode passes bits with no CRC or preamble
      S_DIRECT: begin
        on_next = 1'b1;
        bit_next = pin_s2_reg.data;
        if (!pin_s2_reg.tx_activate) begin
          on_next = 1'b0;
          st_next = S_STANDBY_STATE;
        end
      end
      default: begin
        st_next = S_POWER_DOWN_STATE;
        on_next = 1'b0;
      end
    endcase
    if (reg_wr) begin
      case (reg_addr)
        REG_CTRL:    pwr_next = reg_wdata[CTRL_PWR_UP];
        REG_ADDR_LO: addr_next[31:0] = reg_wdata;
        REG_ADDR_HI: begin
          addr_next[39:32] = reg_wdata[7:0];
          alen_next = reg_wdata[ALEN_LSB +: 6];
        end
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        REG_CTRL:    rd_next = {31'd0, pwr_reg};
        REG_ADDR_LO: rd_next = addr_reg[31:0];
        REG_ADDR_HI: rd_next = {18'd0, alen_reg, addr_reg[39:32]};
        REG_STATUS:  rd_next = {4'd0, last_reg, plen_reg, valid_reg, st_reg};
        REG_CONFIG:  rd_next = {14'd0, cfg_reg};
        // bits times cycles per bit at chosen rate
        REG_AIRTIME: rd_next = {15'd0, 17'(last_reg * bit_cyc)};
        default:     rd_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= S_POWER_DOWN_STATE; wait_reg <= '0; bitc_reg <= '0;
      idx_reg <= '0;   plen_reg <= '0;   cfg_reg <= CFG_RESET;
      shift_reg <= '0; ncfg_reg <= '0;   valid_reg <= 1'b0;
      pwr_reg <= 1'b0; crc_reg <= CRC_INIT; on_reg <= 1'b0;
      bit_reg <= 1'b0; addr_reg <= '0;   alen_reg <= ALEN_RESET;
      last_reg <= '0;  rd_reg <= '0;
    end else begin
      st_reg <= st_next; wait_reg <= wait_next; bitc_reg <= bitc_next;
      idx_reg <= idx_next; plen_reg <= plen_next; cfg_reg <= cfg_next;
      shift_reg <= shift_next; ncfg_reg <= ncfg_next; valid_reg <= valid_next;
      pwr_reg <= pwr_next; crc_reg <= crc_next; on_reg <= on_next;
      bit_reg <= bit_next; addr_reg <= addr_next; alen_reg <= alen_next;
      last_reg <= last_next; rd_reg <= rd_next;
    end
  end

  assign reg_rdata = rd_reg;
  assign tx_on     = on_reg;
  assign tx_bit    = bit_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  first_pre_bit_a: assert property (
    tick && idx_reg == 10'd0 |=> tx_bit == addr_reg[alen - 6'd1])
    else $error("first preamble bit does not follow first address bit");
  pre_toggle_a: assert property (
    tick && idx_reg >= 10'd1 && idx_reg <= 10'd8 |=> tx_bit != $past(tx_bit, 2))
    else $error("preamble or address start does not alternate");
  cfg_needed_a: assert property (
    !valid_reg |-> !(st_reg inside {S_LOAD, S_DIRECT, S_SEND}))
    else $error("active mode without configuration");
  cap_limit_a: assert property (
    st_reg == S_LOAD |-> plen_reg <= cap)
    else $error("payload exceeds capacity");
  send_end_a: assert property (
    tick && idx_reg == total |=> !tx_on && st_reg == S_STANDBY_STATE && last_reg == total)
    else $error("packet length wrong at end");
  cfg_apply_a: assert property (
    st_reg == S_CONFIG && cs_fall |=> valid_reg && st_reg == S_STANDBY_STATE)
    else $error("configuration not applied on select fall");
  bit_gap_a: assert property (
    tick && idx_reg != total |=> !tick [*8])
    else $error("bit period shorter than expected");
  settle_hold_a: assert property (
    st_reg == S_POWER_DOWN_STATE && pwr_reg |=> st_reg == S_SETTLE [*8])
    else $error("left settling too early");
  direct_pass_a: assert property (
    st_reg == S_DIRECT && pin_s2_reg.tx_activate |=> tx_bit == $past(pin_s2_reg.data) && tx_on)
    else $error("direct mode bit not passed through");
endmodule // btx_packet_ctrl
`default_nettype wire

// >>> tb/btx_radio_model.sv
// Controller model driving the radio port pins of the packet control.
// Assumes the 20 MHz clk; serial clock runs only inside frames, 400 ns period.
`timescale 1ns/1ns
`default_nettype none
module btx_radio_model
  import btx_pkg::*;
(
  input  wire logic      clk,
  output var  btx_pins_t pins
);
  initial pins = '0;

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic shift_bit(input logic b);
    pins.data <= b;
    tick(4);
    pins.serial_clock <= 1'b1;
    tick(4);
    pins.serial_clock <= 1'b0;
  endtask

  // No pull on data: a released line shows the inverse, not the last value
  task automatic release_data();
    pins.data <= ~pins.data;
  endtask

  task automatic configure(input logic [CFG_W-1:0] w);
    pins.cfg_select <= 1'b1;
    tick(5 * CLK_PER_US);
    for (int i = CFG_W - 1; i >= 0; i--) shift_bit(w[i]);
    tick(4);
    pins.cfg_select <= 1'b0;
    release_data();
  endtask

  task automatic activate(input logic on);
    pins.tx_activate <= on;
    tick(on ? 5 * CLK_PER_US : 1);
    if (!on) release_data();
  endtask

  task automatic finish(input int bit_cyc);
    tick(bit_cyc);
    activate(1'b0);
  endtask
endmodule // btx_radio_model
`default_nettype wire

// >>> tb/test_btx_packet_ctrl.sv
// Self-checking bench for the packet control, driven through the radio model.
// Assumes the settle count is shortened by parameter to keep runs short.
`timescale 1ns/1ns
`default_nettype none
module test_btx_packet_ctrl;
  import btx_pkg::*;
  localparam int SETTLE = 50;
  typedef struct {
    logic [17:0] cfg;
    int          alen;
    logic [39:0] addr;
    int          npay;
  } btx_row_t;

  logic        clk;
  logic        rst_n;
  logic [2:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        tx_on;
  logic        tx_bit;
  btx_pins_t   pins;
  int          mismatches = 0;
  int          compares = 0;
  btx_row_t    rows [3] = '{
    '{18'h0_4000, 8, 40'h00_0000_00a5, 16},
    '{18'h1_6000, 24, 40'h00_003c_5a01, 40},
    '{18'h3_6000, 40, 40'h12_3456_789a, 210}};

  btx_packet_ctrl #(.PD2SBY_CYCLES(SETTLE)) btx_packet_ctrl_inst (
    .clk(clk), .rst_n(rst_n), .cfg_select(pins.cfg_select),
    .tx_activate(pins.tx_activate), .radio_serial_clock(pins.serial_clock),
    .radio_data(pins.data), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tx_on(tx_on), .tx_bit(tx_bit));
  btx_radio_model btx_radio_model_inst (.clk(clk), .pins(pins));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic wrap_up();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic reg_write(input logic [2:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [2:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic wait_tx(input logic v, input int bound);
    int n;
    n = 0;
    while (tx_on !== v) begin
      @(posedge clk);
      #1;
      n++;
      if (n > bound) begin
        mismatches++;
        $display("BAD %0t tx_on never reached %b", $time, v);
        wrap_up();
      end
    end
  endtask

  task automatic power_cycle();
    logic [31:0] r;
    reg_write(REG_CTRL, 32'h0000_0000);
    reg_write(REG_CTRL, 32'h0000_0001);
    reg_read(REG_STATUS, r);
    check(r[7:0], S_SETTLE, "settling");
    repeat (SETTLE + 10) @(posedge clk);
    reg_read(REG_STATUS, r);
    check(r[7:0], S_STANDBY_STATE, "standby");
  endtask

  task automatic run_row(input btx_row_t w);
    int          crc;
    int          bc;
    int          npl;
    int          tot;
    logic [31:0] r;
    logic        e;
    crc = w.cfg[CFG_CRC_EN] ? (w.cfg[CFG_CRC_L] ? CRC_LONG : CRC_SHORT) : 0;
    bc = w.cfg[CFG_RATE] ? BIT_CYC_HI : BIT_CYC_LO;
    npl = (w.npay < PKT_BITS - w.alen - crc) ? w.npay : PKT_BITS - w.alen - crc;
    tot = PRE_BITS + w.alen + npl + crc;
    reg_write(REG_ADDR_LO, w.addr[31:0]);
    reg_write(REG_ADDR_HI, {18'h0, w.alen[5:0], w.addr[39:32]});
    btx_radio_model_inst.configure(w.cfg);
    repeat (8) @(posedge clk);
    reg_read(REG_CONFIG, r);
    check(r, {14'h0, w.cfg}, "config word");
    // Power-down with valid config, then straight to transmit
    power_cycle();
    btx_radio_model_inst.activate(1'b1);
    for (int i = 0; i < w.npay; i++) btx_radio_model_inst.shift_bit(i % 3 == 0);
    btx_radio_model_inst.activate(1'b0);
    wait_tx(1'b1, SB2TX_CYC + 200);
    repeat (1 + bc / 2) @(posedge clk);
    for (int i = 0; i < tot - crc; i++) begin
      if (i < PRE_BITS)
        e = w.addr[w.alen - 1] ? PRE_ADDR1[7 - i] : PRE_ADDR0[7 - i];
      else if (i < PRE_BITS + w.alen)
        e = w.addr[w.alen - 1 - (i - PRE_BITS)];
      else
        e = ((i - PRE_BITS - w.alen) % 3 == 0);
      check({tx_on, tx_bit}, {1'b1, e}, "packet bit");
      repeat (bc) @(posedge clk);
    end
    wait_tx(1'b0, (crc + 3) * bc);
    reg_read(REG_AIRTIME, r);
    check(r, tot * bc, "air time");
    reg_read(REG_STATUS, r);
    check(r[27:18], tot[9:0], "packet bits");
  endtask

  initial begin
    logic [31:0] r;
    logic [15:0] dpk;
    int          n;
    rst_n = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 32'h0000_0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (16) @(posedge clk);
    #1;
    check({30'h0, tx_on, tx_bit}, 32'h0000_0000, "reset pins");
    check(reg_rdata, 32'h0000_0000, "reset read data");
    rst_n <= 1'b1;
    reg_read(REG_STATUS, r);
    check(r[8:0], {1'b0, S_POWER_DOWN_STATE}, "reset status");
    reg_read(3'h7, r);
    check(r, 32'h0000_0000, "unmapped read");
    // Leave power-down first; select is ignored until standby
    power_cycle();
    foreach (rows[k]) run_row(rows[k]);
    // Direct mode: the bench shifts in the preamble itself, no CRC follows
    dpk = {PRE_ADDR0, 8'h3c};
    btx_radio_model_inst.configure(18'h1_2000);
    btx_radio_model_inst.activate(1'b1);
    for (int i = 0; i < 16; i++) begin
      btx_radio_model_inst.shift_bit(dpk[15 - i]);
      check({tx_on, tx_bit}, {1'b1, dpk[15 - i]}, "direct bit");
    end
    btx_radio_model_inst.finish(BIT_CYC_HI);
    wait_tx(1'b0, 40);
    // Supply loss drops the configuration; activate must be ignored
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    reg_read(REG_CONFIG, r);
    check(r, {14'h0, CFG_RESET}, "config lost");
    power_cycle();
    btx_radio_model_inst.activate(1'b1);
    for (int i = 0; i < 8; i++) btx_radio_model_inst.shift_bit(i[0]);
    btx_radio_model_inst.activate(1'b0);
    n = 0;
    repeat (SB2TX_CYC + 400) begin
      @(posedge clk);
      #1;
      n += (tx_on !== 1'b0);
    end
    check(n, 0, "unconfigured send");
    wrap_up();
  end
endmodule // test_btx_packet_ctrl
`default_nettype wire
